/* File: rtl/vp_pkg.sv */
package vp_pkg;
   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 20_000_000;
   localparam int unsigned VALVE_OPEN_S   = 4;
   localparam int unsigned IGNORE_S       = 3;
   localparam int unsigned TICK_CYCLES    = CLK_HZ;   // One second
   localparam int unsigned TEST_TIME_MAX_S = 3600;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFFSET   = 8'h00;
   localparam logic [7:0] TTIME_OFFSET  = 8'h04;
   localparam logic [7:0] STATUS_OFFSET = 8'h08;
   localparam logic [7:0] IRQST_OFFSET  = 8'h0C;
   localparam logic [7:0] IRQMSK_OFFSET = 8'h10;

   // Control fields
   localparam int unsigned CTRL_SCHED_LSB = 0;    // [2:0]
   localparam int unsigned CTRL_RESET_BIT = 8;    // Write one: clear lockout
   localparam logic [2:0]  SCHED_RESET    = 3'h0;
   localparam logic [11:0] TTIME_RESET    = 12'h000;

   // Interrupt bit positions
   localparam int unsigned IRQ_DONE    = 0;
   localparam int unsigned IRQ_LOCKOUT = 1;
   localparam int unsigned IRQ_W       = 2;

   // Lockout causes
   localparam logic [1:0] CAUSE_NONE   = 2'h0;
   localparam logic [1:0] CAUSE_UPLEAK = 2'h1;
   localparam logic [1:0] CAUSE_DNLEAK = 2'h2;
   localparam logic [1:0] CAUSE_CONFIG = 2'h3;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SCHED_NEVER  = 3'b000,
      SCHED_BEFORE = 3'b001,
      SCHED_AFTER  = 3'b010,
      SCHED_BOTH   = 3'b011,
      SCHED_SPLIT  = 3'b100
   } sched_type;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_LP_OPEN = 3'b001,
      ST_LP_WAIT = 3'b010,
      ST_LP_MON  = 3'b011,
      ST_HP_OPEN = 3'b100,
      ST_HP_WAIT = 3'b101,
      ST_HP_MON  = 3'b110,
      ST_LOCKOUT = 3'b111
   } vp_state_type;
endpackage

/* File: rtl/vp_second_tick.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// One pulse per second from the system clock
// ----------------------------------------------------------------
module vp_second_tick #(
   // Cycles per second
   parameter int unsigned TICK_N = vp_pkg::TICK_CYCLES
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // Restart phase so each interval starts on a full second
   input  wire logic restart,
   // Output
   output logic      tick
);
   import vp_pkg::*;

   localparam logic [24:0] TICK_LAST = 25'(TICK_N - 1);
   logic [24:0] cnt_r;

   // Exact count keeps every interval far inside its tolerance
   always_ff @(posedge clk) begin
      if (!resetn || restart) begin
         cnt_r <= 25'h000_0000;
         tick  <= 1'b0;
      end else if (cnt_r == TICK_LAST) begin
         cnt_r <= 25'h000_0000;
         tick  <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 25'h000_0001;
         tick  <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/vp_sequencer.sv */
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Five schedule choices; reset default runs no proving test at all.
// - Before schedule runs the full test during prepurge.
// - After schedule runs the full test after run, alongside postpurge.
// - Both schedule runs the full test at before and after points.
// - Split runs high pressure check before, low pressure check after.
// - Tests start only while the proving demand input is high.
// - Each monitoring window lasts the programmed test time.
// - Low test: downstream valve open, upstream closed, for four seconds.
// - Then three seconds with the pressure switch ignored.
// - Switch on during low test window causes upstream leak lockout.
// - High test: upstream valve open, downstream closed, four seconds.
// - Then three seconds with the pressure switch ignored.
// - Switch off during high test window causes downstream leak lockout.
// - All intervals held well within ten percent of nominal.
// - Test time steps: 1 s to 60, 10 s to 600, 1 min to 3600.
// - Demand while schedule is never causes lockout.
// - Main valve prepurge check suppressed while proving drives valves.
module vp_sequencer #(
   // Cycles per second; a bench may shorten it to reach the later phases
   parameter int unsigned TICK_N = vp_pkg::TICK_CYCLES
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // AXI4-Lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Burner sequence points
   input  wire logic        proving_demand,
   input  wire logic        before_point,
   input  wire logic        after_point,
   // Valve train
   input  wire logic        interspace_pressure_switch,
   output logic             upstream_valve_drive,
   output logic             downstream_valve_drive,
   // Status to the burner sequencer
   output logic             proving_active,
   output logic             proving_done,
   output logic             lockout,
   output logic             irq
);
   import vp_pkg::*;

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [2:0]       sched_r;
   logic [11:0]      ttime_r;
   logic [IRQ_W-1:0] irq_st_r;
   logic [IRQ_W-1:0] irq_msk_r;
   logic [1:0]       cause_r;
   logic             aw_hold_r;
   logic             w_hold_r;
   logic [7:0]       awaddr_r;
   logic [31:0]      wdata_r;
   logic [3:0]       wstrb_r;
   logic             wr_go;
   logic             clr_lock;
   vp_state_type     state_r;
   logic             done_ev;
   logic             lock_ev;

   // Snap a test time to its step grid, largest legal value below
   function automatic logic [11:0] snap_time(input logic [11:0] t);
      logic [11:0] r;
      r = t;
      if (t > 12'(TEST_TIME_MAX_S))
         r = 12'(TEST_TIME_MAX_S);
      else if (t > 12'd600)
         r = 12'((t / 12'd60) * 12'd60);
      else if (t > 12'd60)
         r = 12'((t / 12'd10) * 12'd10);
      return r;
   endfunction

   assign wr_go    = aw_hold_r && w_hold_r && !s_axi_bvalid;
   assign clr_lock = wr_go && (awaddr_r == CTRL_OFFSET) && wstrb_r[1]
                     && wdata_r[CTRL_RESET_BIT];

   // Address and data taken in either order, held until the write fires
   always_ff @(posedge clk) begin
      if (!resetn) begin
         aw_hold_r     <= 1'b0;
         w_hold_r      <= 1'b0;
         awaddr_r      <= 8'h00;
         wdata_r       <= 32'h0000_0000;
         wstrb_r       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_hold_r && !s_axi_awready;
         s_axi_wready  <= !w_hold_r && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_hold_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end else if (wr_go) begin
            w_hold_r <= 1'b0;
         end
      end
   end

   // Write response; unmapped addresses answer SLVERR
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (awaddr_r <= IRQMSK_OFFSET && awaddr_r[1:0] == 2'b00)
                         ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Configuration writes; the schedule is frozen while a test runs
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sched_r   <= SCHED_RESET;
         ttime_r   <= TTIME_RESET;
         irq_msk_r <= '0;
      end else if (wr_go) begin
         if (awaddr_r == CTRL_OFFSET && wstrb_r[0] && state_r == ST_IDLE)
            sched_r <= (wdata_r[2:0] > SCHED_SPLIT) ? SCHED_RESET : wdata_r[2:0];
         if (awaddr_r == TTIME_OFFSET && wstrb_r[1:0] == 2'b11 && state_r == ST_IDLE)
            ttime_r <= snap_time(wdata_r[11:0]);
         if (awaddr_r == IRQMSK_OFFSET && wstrb_r[0])
            irq_msk_r <= wdata_r[IRQ_W-1:0];
      end
   end

   // Sticky events, write one to clear; a new event wins over the clear
   always_ff @(posedge clk) begin
      if (!resetn) begin
         irq_st_r <= '0;
         irq      <= 1'b0;
      end else begin
         for (int i = 0; i < IRQ_W; i++) begin
            if ((i == IRQ_DONE && done_ev) || (i == IRQ_LOCKOUT && lock_ev))
               irq_st_r[i] <= 1'b1;
            else if (wr_go && awaddr_r == IRQST_OFFSET && wstrb_r[0] && wdata_r[i])
               irq_st_r[i] <= 1'b0;
         end
         irq <= |(irq_st_r & irq_msk_r);
      end
   end

   // Read channel, one cycle after the address is taken
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'b00;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            unique case (s_axi_araddr)
               CTRL_OFFSET:   s_axi_rdata <= {29'h0, sched_r};
               TTIME_OFFSET:  s_axi_rdata <= {20'h0, ttime_r};
               STATUS_OFFSET: s_axi_rdata <= {24'h0, cause_r, lockout,
                                              proving_active, 1'b0, state_r};
               IRQST_OFFSET:  s_axi_rdata <= {30'h0, irq_st_r};
               IRQMSK_OFFSET: s_axi_rdata <= {30'h0, irq_msk_r};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Proving sequencer
   // ----------------------------------------------------------------
   logic        tick;
   logic        restart;
   logic [11:0] secs_r;
   logic        before_d_r;
   logic        after_d_r;
   logic        want_lp_r;
   logic        want_hp_r;
   logic        start_before;
   logic        start_after;

   vp_second_tick #(
      .TICK_N (TICK_N)
   ) u_tick (
      .clk    (clk),
      .resetn (resetn),
      .restart(restart),
      .tick   (tick)
   );

   // Test starts on the rising edge of a sequence point, only with demand
   assign start_before = before_point && !before_d_r && proving_demand
                         && (sched_r != SCHED_NEVER) && (sched_r != SCHED_AFTER);
   assign start_after  = after_point && !after_d_r && proving_demand
                         && (sched_r != SCHED_NEVER) && (sched_r != SCHED_BEFORE);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         before_d_r <= 1'b0;
         after_d_r  <= 1'b0;
      end else begin
         before_d_r <= before_point;
         after_d_r  <= after_point;
      end
   end

   // Phase timer restarts on entry to each open, wait and monitor phase
   always_ff @(posedge clk) begin
      if (!resetn || restart)
         secs_r <= 12'h000;
      else if (tick)
         secs_r <= secs_r + 12'h001;
   end

   // Main state machine; restart lands one cycle after a state change, so
   // that cycle still sees the old phase's count and is never a timed exit
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_r   <= ST_IDLE;
         restart   <= 1'b0;
         want_lp_r <= 1'b0;
         want_hp_r <= 1'b0;
         cause_r   <= CAUSE_NONE;
         done_ev   <= 1'b0;
         lock_ev   <= 1'b0;
      end else begin
         restart <= 1'b0;
         done_ev <= 1'b0;
         lock_ev <= 1'b0;
         unique case (state_r)
            ST_IDLE: begin
               if (proving_demand && sched_r == SCHED_NEVER) begin
                  state_r <= ST_LOCKOUT;
                  cause_r <= CAUSE_CONFIG;
                  lock_ev <= 1'b1;
               end else if (start_before || start_after) begin
                  restart <= 1'b1;
                  if (sched_r == SCHED_SPLIT && start_before) begin
                     want_hp_r <= 1'b1;
                     state_r   <= ST_HP_OPEN;
                  end else begin
                     want_lp_r <= 1'b1;
                     want_hp_r <= (sched_r != SCHED_SPLIT);
                     state_r   <= ST_LP_OPEN;
                  end
               end
            end
            ST_LP_OPEN:
               if (!restart && tick && secs_r == 12'(VALVE_OPEN_S - 1)) begin
                  state_r <= ST_LP_WAIT;
                  restart <= 1'b1;
               end
            ST_LP_WAIT:
               if (!restart && tick && secs_r == 12'(IGNORE_S - 1)) begin
                  state_r <= ST_LP_MON;
                  restart <= 1'b1;
               end
            ST_LP_MON:
               if (interspace_pressure_switch) begin
                  state_r <= ST_LOCKOUT;
                  cause_r <= CAUSE_UPLEAK;
                  lock_ev <= 1'b1;
               end else if (!restart && secs_r >= ttime_r) begin
                  restart <= 1'b1;
                  if (want_hp_r) begin
                     state_r <= ST_HP_OPEN;
                  end else begin
                     state_r <= ST_IDLE;
                     done_ev <= 1'b1;
                  end
                  want_lp_r <= 1'b0;
               end
            ST_HP_OPEN:
               if (!restart && tick && secs_r == 12'(VALVE_OPEN_S - 1)) begin
                  state_r <= ST_HP_WAIT;
                  restart <= 1'b1;
               end
            ST_HP_WAIT:
               if (!restart && tick && secs_r == 12'(IGNORE_S - 1)) begin
                  state_r <= ST_HP_MON;
                  restart <= 1'b1;
               end
            ST_HP_MON:
               if (!interspace_pressure_switch) begin
                  state_r <= ST_LOCKOUT;
                  cause_r <= CAUSE_DNLEAK;
                  lock_ev <= 1'b1;
               end else if (!restart && secs_r >= ttime_r) begin
                  state_r   <= ST_IDLE;
                  want_hp_r <= 1'b0;
                  done_ev   <= 1'b1;
               end
            ST_LOCKOUT:
               if (clr_lock) begin
                  state_r   <= ST_IDLE;
                  cause_r   <= CAUSE_NONE;
                  want_lp_r <= 1'b0;
                  want_hp_r <= 1'b0;
               end
         endcase
      end
   end

   // Registered outputs, valves decoded from state_r one cycle behind it
   always_ff @(posedge clk) begin
      if (!resetn) begin
         upstream_valve_drive   <= 1'b0;
         downstream_valve_drive <= 1'b0;
         proving_active         <= 1'b0;
         proving_done           <= 1'b0;
         lockout                <= 1'b0;
      end else begin
         upstream_valve_drive   <= (state_r == ST_HP_OPEN);
         downstream_valve_drive <= (state_r == ST_LP_OPEN);
         // Burner logic masks its main valve check with this flag
         proving_active         <= (state_r != ST_IDLE) && (state_r != ST_LOCKOUT);
         proving_done           <= done_ev;
         lockout                <= (state_r == ST_LOCKOUT);
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_never_valves;
      @(posedge clk) disable iff (!resetn)
         sched_r == SCHED_NEVER |-> ##1 !upstream_valve_drive && !downstream_valve_drive;
   endproperty
   a_never_valves: assert property (p_never_valves) else $error("valve driven under never");

   property p_exclusive;
      @(posedge clk) disable iff (!resetn)
         !(upstream_valve_drive && downstream_valve_drive);
   endproperty
   a_exclusive: assert property (p_exclusive) else $error("both valves open");

   property p_no_demand_no_start;
      @(posedge clk) disable iff (!resetn)
         state_r == ST_IDLE && !proving_demand |=> state_r inside {ST_IDLE};
   endproperty
   a_no_demand_no_start: assert property (p_no_demand_no_start) else $error("start without demand");

   property p_config_lock;
      @(posedge clk) disable iff (!resetn)
         state_r == ST_IDLE && proving_demand && sched_r == SCHED_NEVER
         |=> state_r == ST_LOCKOUT && cause_r == CAUSE_CONFIG;
   endproperty
   a_config_lock: assert property (p_config_lock) else $error("no config lockout");

   property p_lp_leak;
      @(posedge clk) disable iff (!resetn)
         state_r == ST_LP_MON && interspace_pressure_switch
         |=> state_r == ST_LOCKOUT ##1 !downstream_valve_drive && lockout;
   endproperty
   a_lp_leak: assert property (p_lp_leak) else $error("upstream leak missed");

   property p_hp_leak;
      @(posedge clk) disable iff (!resetn)
         state_r == ST_HP_MON && !interspace_pressure_switch
         |=> state_r == ST_LOCKOUT && cause_r == CAUSE_DNLEAK;
   endproperty
   a_hp_leak: assert property (p_hp_leak) else $error("downstream leak missed");

   property p_lock_hold;
      @(posedge clk) disable iff (!resetn)
         state_r == ST_LOCKOUT && !clr_lock |=> state_r == ST_LOCKOUT;
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lockout released");

   property p_lock_valves;
      @(posedge clk) disable iff (!resetn)
         lockout |-> !upstream_valve_drive && !downstream_valve_drive;
   endproperty
   a_lock_valves: assert property (p_lock_valves) else $error("valve on in lockout");

   property p_ignore;
      @(posedge clk) disable iff (!resetn)
         state_r == ST_HP_WAIT && secs_r < 12'(IGNORE_S - 1) |=> state_r == ST_HP_WAIT;
   endproperty
   a_ignore: assert property (p_ignore) else $error("ignore delay cut short");

   property p_split_order;
      @(posedge clk) disable iff (!resetn)
         state_r == ST_IDLE && start_before && sched_r == SCHED_SPLIT
         && !(proving_demand && sched_r == SCHED_NEVER) |=> state_r == ST_HP_OPEN;
   endproperty
   a_split_order: assert property (p_split_order) else $error("split order wrong");

   c_done:    cover property (@(posedge clk) disable iff (!resetn) proving_done);
   c_uplock:  cover property (@(posedge clk) disable iff (!resetn) cause_r == CAUSE_UPLEAK);
   c_dnlock:  cover property (@(posedge clk) disable iff (!resetn) cause_r == CAUSE_DNLEAK);
   c_lp_to_hp: cover property (@(posedge clk) disable iff (!resetn)
                               state_r == ST_LP_MON ##1 state_r == ST_HP_OPEN);
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import vp_pkg::*;
   localparam int TN = 50;   // Short second so whole tests fit the run
   logic        clk, resetn, awv, wv, bready, arv, rready, dem, bp, ap, leak, leakd;
   logic        awready, wready, bvalid, arready, rvalid, sw, upv, dnv;
   logic        act, done, lock, irq;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0]  bresp, rresp, resp, e;
   int          err_total, total_checks, seed, t, k, s, pt, n_dn, n_up, n_cy, got;

   // ----
   // Clock, design and far side
   // ----
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   vp_sequencer #(.TICK_N(TN)) dut_u (
      .clk(clk), .resetn(resetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .proving_demand(dem), .before_point(bp), .after_point(ap),
      .interspace_pressure_switch(sw), .upstream_valve_drive(upv),
      .downstream_valve_drive(dnv), .proving_active(act), .proving_done(done),
      .lockout(lock), .irq(irq));
   valve_train vt_u (.clk(clk), .up_open(upv), .dn_open(dnv), .leak_up(leak),
                     .leak_dn(leakd), .sw(sw));

   // ----
   // Shared tasks
   // ----
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask
   task automatic rst;
      resetn <= 1'b0;
      dem <= 1'b0;
      bp <= 1'b0;
      ap <= 1'b0;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
   endtask
   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (awv && awready) awv <= 1'b0;
         if (wv && wready) wv <= 1'b0;
         if (bvalid) begin
            resp = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (arv && arready) arv <= 1'b0;
         if (rvalid) begin
            rd = rdata;
            resp = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask
   // Test time model: seconds snapped down to the step grid
   function automatic int snap(int v);
      if (v <= 60) return v;
      if (v <= 600) return v - v % 10;
      return v - v % 60;
   endfunction
   // Interval model: nominal within ten percent
   function automatic int in_tol(int n, int nom);
      return (n * 10 >= nom * 9) && (n * 10 <= nom * 11);
   endfunction
   task automatic finish_test;
      if (err_total == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ----
   // Scenarios
   // ----
   initial begin
      seed = 3;
      err_total = 0;
      total_checks = 0;
      {awv, wv, arv, bready, rready, leak, leakd} = '0;
      {awaddr, araddr, wdata} = '0;
      rst;
      rd_reg(CTRL_OFFSET); chk(rd, 0);
      rd_reg(8'h14); chk(resp, 2'b10);
      wr(8'h14, 0); chk(resp, 2'b10);
      for (k = 0; k < 4; k++) begin
         t = {$random(seed)} % 3601;
         wr(TTIME_OFFSET, t);
         rd_reg(TTIME_OFFSET); chk(rd, snap(t));
      end
      wr(CTRL_OFFSET, 7); rd_reg(CTRL_OFFSET); chk(rd, 0);
      // Demand with no schedule, interrupt masked at first
      leak <= 1'b1;
      dem <= 1'b1;
      repeat (4) @(posedge clk);
      chk(lock, 1); chk({upv, dnv}, 0); chk(irq, 0);
      rd_reg(STATUS_OFFSET); chk(rd[7:5], 3'b111);
      dem <= 1'b0;
      repeat (20) @(posedge clk);
      chk(lock, 1);
      wr(IRQMSK_OFFSET, 2);
      repeat (2) @(posedge clk);
      chk(irq, 1);
      wr(CTRL_OFFSET, 32'h0000_0100);
      wr(IRQST_OFFSET, 2);
      repeat (2) @(posedge clk);
      chk(lock, 0); chk(irq, 0);
      leak <= 1'b0;
      // Every schedule except never at both points, then one point without demand
      for (k = 0; k < 9; k++) begin
         s = k % 4 + 1;
         pt = k / 4 % 2;
         rst;
         wr(CTRL_OFFSET, s);
         dem <= (k < 8);
         e = 2'b00;
         if (k < 8 && s == 4) e = pt ? 2'b01 : 2'b10;
         else if (k < 8 && (s == 3 || s == pt + 1)) e = 2'b01;
         @(posedge clk);
         if (pt) ap <= 1'b1;
         else bp <= 1'b1;
         repeat (4) @(posedge clk);
         chk({upv, dnv}, e);
         chk(act, e != 0);
         chk(lock, 0);
      end
      // Both checks in full at the before point, tight seats
      rst;
      wr(TTIME_OFFSET, 2);
      wr(CTRL_OFFSET, 3);
      dem <= 1'b1;
      bp <= 1'b1;
      {n_dn, n_up, n_cy, got} = '0;
      while (!got && n_cy < 40 * TN) begin
         @(posedge clk);
         n_cy++;
         n_dn += dnv;
         n_up += upv;
         got = (done === 1'b1);
      end
      chk(got, 1);
      chk(lock, 0);
      chk(in_tol(n_dn, 4 * TN), 1);
      chk(in_tol(n_up, 4 * TN), 1);
      chk(in_tol(n_cy, 18 * TN), 1);
      rd_reg(IRQST_OFFSET); chk(rd[0], 1);
      // Seeded leaks: upstream seat under before, downstream seat under split
      for (k = 0; k < 2; k++) begin
         rst;
         wr(TTIME_OFFSET, 2);
         wr(CTRL_OFFSET, k ? 4 : 1);
         leak <= (k == 0);
         leakd <= (k == 1);
         dem <= 1'b1;
         bp <= 1'b1;
         n_cy = 0;
         while (lock !== 1'b1 && n_cy < 20 * TN) begin
            @(posedge clk);
            n_cy++;
         end
         chk(in_tol(n_cy, 7 * TN), 1);
         chk({upv, dnv}, 0);
         rd_reg(STATUS_OFFSET); chk(rd[7:6], k + 1);
      end
      finish_test;
   end

   // Run needs a few thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      finish_test;
   end
endmodule
`default_nettype wire

/* File: tb/valve_train.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// Valve solenoids and interspace pressure switch
// ----
module valve_train (
   // Clock
   input  wire logic clk,
   // Solenoids and seeded seat leak
   input  wire logic up_open,
   input  wire logic dn_open,
   input  wire logic leak_up,
   input  wire logic leak_dn,
   // Pressure switch, high with pressure present
   output logic      sw
);
   // Open valves win; with both closed a leaky seat bleeds or fills the space
   initial sw = 1'b0;
   always @(posedge clk) begin
      if (dn_open)
         sw <= 1'b0;
      else if (up_open)
         sw <= 1'b1;
      else if (leak_dn)
         sw <= 1'b0;
      else if (leak_up)
         sw <= 1'b1;
   end
endmodule
`default_nettype wire
